// ---- bridge_params.svh ----
`ifndef BRIDGE_PARAMS_SVH
`define BRIDGE_PARAMS_SVH

// channel numbers
`define CH_PERIPH       2'h0
`define CH_VWIRE        2'h1
`define CH_OOB          2'h2
`define CH_FLASH        2'h3

// flash cycle types
`define FL_READ         2'h0
`define FL_WRITE        2'h1
`define FL_ERASE        2'h2

// out-of-band destination addresses for the local responders
`define OOB_TEMP_ADDR   8'h01
`define OOB_TIME_ADDR   8'h02

// completion status
`define CPL_OK          2'h0
`define CPL_UNSUCC      2'h1

// slave capability bit per channel
`define CAP_W           4

// thermal refresh period and rtc capture period
`define TEMP_PERIOD_US  1000
`define CLK_MHZ         20
`define TEMP_CYCLES     (`TEMP_PERIOD_US * `CLK_MHZ)
`define RTC_CYCLES      20000

// number of time bytes in the time response
`define TIME_BYTES      7

// flag bit positions in the time flag byte
`define FLAG_DS         0
`define FLAG_HF         1
`define FLAG_DM         2

`endif

// ---- bridge_pkg.sv ----
package bridge_pkg;
  typedef enum logic [4:0] {
    ST_RESET  = 5'h01,
    ST_CONFIG = 5'h02,
    ST_IDLE   = 5'h04,
    ST_FLASH  = 5'h08,
    ST_REPLY  = 5'h10
  } link_state_e;
  typedef logic [7:0] byte_t;
endpackage

// ---- pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ---- period_tick.sv ----
`timescale 1ns/1ps
`default_nettype none
module period_tick #(
  parameter int PERIOD = 20000
) (
  input  wire logic core_clk,
  input  wire logic srst,
  output var  logic tick
);
  logic [31:0] cnt_reg;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_reg <= 32'h0;
      tick    <= 1'b0;
    end else if (cnt_reg == 32'(PERIOD - 1)) begin
      cnt_reg <= 32'h0;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
      tick    <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- espi_channel_bridge.sv ----
// Contract
// - channel 0 carries memory and I/O cycles
// - channel 1 carries posted virtual wires only
// - channel 2 carries posted packet transfers only; code still replies to non-posted temperature and time requests
// - channel 3 carries non-posted flash requests only
// - per-channel queues, no cross-channel ordering; code has no queues and serves flash before a pending oob reply
// - learn slave channels via get configuration
// - forward host I/O/memory in enabled ranges
// - forward slave memory requests to host
// - virtual wire directions and reset domains
// - IRQ group becomes interrupt controller message
// - interrupts transported, no state kept
// - management packets forwarded unchanged
// - return periodic temperature byte on request
// - return captured time on request
// - seven time bytes in one packet
// - daylight-saving flag reflects applied saving
// - hour-format flag, bit seven PM
// - data-mode flag: binary one, bcd zero
// - flash request passed, completion returned; code drops requests that arrive outside ST_IDLE, with no completion
// - flash channel accepts read/write/erase only
// - slave uses linear flash addresses
// - transfers are whole bytes
`timescale 1ns/1ps
`default_nettype none
`include "bridge_params.svh"
module espi_channel_bridge (
  input  wire logic         core_clk,
  input  wire logic         srst,
  // link clock from the physical layer, only sampled
  input  wire logic         link_clk,
  input  wire logic         link_reset_n,
  input  wire logic         platform_reset_n,
  input  wire logic         deep_sleep_power_good,
  // configuration
  input  wire logic         cfg_done,
  input  wire logic [3:0]   cfg_slave_caps,
  output logic              cfg_get_req,
  output logic [3:0]        chan_enabled,
  // decoded inbound packets (byte granular)
  input  wire logic         rx_valid,
  input  wire logic [1:0]   rx_chan,
  input  wire logic         rx_posted,
  input  wire logic [7:0]   rx_byte,
  input  wire logic [7:0]   rx_addr,
  input  wire logic [1:0]   rx_cycle,
  input  wire logic         rx_last,
  output logic              rx_reject,
  // host side peripheral requests
  input  wire logic         host_io_req,
  input  wire logic         host_mem_req,
  input  wire logic         host_in_fixed,
  input  wire logic         host_in_prog,
  input  wire logic         range_en,
  output logic              periph_fwd,
  output logic              host_mem_fwd,
  // virtual wires towards slave
  input  wire logic         suspend_status_wire,
  input  wire logic         suspend_powerdown_ack_wire,
  input  wire logic         platform_reset_wire,
  input  wire logic         sleep_a_wire,
  input  wire logic [4:0]   deep_sleep_wires,
  output logic [3:0]        vw_out_reg_o,
  output logic [4:0]        vw_deep_reg_o,
  // virtual wires from slave: pme, wake, smi, sci, kbd reset
  output logic              power_event_wire,
  output logic              wake_wire,
  output logic              system_mgmt_irq_wire,
  output logic              system_control_irq_wire,
  output logic              keyboard_reset_wire,
  output logic              irq_msg_valid,
  output logic [7:0]        irq_msg_line,
  output logic              irq_msg_level,
  // out-of-band path
  output logic              mgmt_valid,
  output logic [7:0]        mgmt_byte,
  output logic              mgmt_last,
  input  wire logic [7:0]   thermal_byte,
  input  wire logic [55:0]  rtc_bytes,
  input  wire logic         rtc_dst,
  input  wire logic         rtc_24h,
  input  wire logic         rtc_binary,
  output logic              oob_tx_valid,
  output logic [7:0]        oob_tx_byte,
  output logic              oob_tx_last,
  // flash controller
  output logic              flash_req,
  output logic [1:0]        flash_cycle,
  output logic [7:0]        flash_data,
  input  wire logic         flash_done,
  input  wire logic [7:0]   flash_rdata,
  output logic              flash_cpl_valid,
  output logic [1:0]        flash_cpl_status,
  output logic [7:0]        flash_cpl_data
);
  bridge_pkg::link_state_e state_reg;
  logic [1:0]  link_rst_s;
  logic        dsw_ok_s;
  logic        link_clk_s;
  logic        link_clk_d;
  logic        link_rise;
  logic        temp_tick;
  logic        rtc_tick;
  logic [7:0]  temp_reg;
  logic [55:0] rtc_snap_reg;
  logic [2:0]  rtc_flag_reg;
  logic [71:0] reply_reg;
  logic [3:0]  reply_cnt_reg;
  logic        chan_ok;

  pin_sync #(.W(4)) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .async_in ({link_clk, link_reset_n, platform_reset_n, deep_sleep_power_good}),
    .sync_out ({link_clk_s, link_rst_s, dsw_ok_s})
  );

  period_tick #(.PERIOD(`TEMP_CYCLES)) u_temp_tick (
    .core_clk (core_clk),
    .srst     (srst),
    .tick     (temp_tick)
  );

  period_tick #(.PERIOD(`RTC_CYCLES)) u_rtc_tick (
    .core_clk (core_clk),
    .srst     (srst),
    .tick     (rtc_tick)
  );

  // link clock edges are only observed for activity, never used as a clock
  always_ff @(posedge core_clk) begin
    if (srst) begin
      link_clk_d <= 1'b0;
    end else begin
      link_clk_d <= link_clk_s;
    end
  end
  assign link_rise = link_clk_s & ~link_clk_d;

  // a channel is usable only when the slave reported it
  assign chan_ok = chan_enabled[rx_chan];

  always_ff @(posedge core_clk) begin
    if (srst || !link_rst_s[1]) begin
      state_reg    <= bridge_pkg::ST_RESET;
      cfg_get_req  <= 1'b0;
      chan_enabled <= 4'h0;
    end else begin
      cfg_get_req <= 1'b0;
      case (state_reg)
        bridge_pkg::ST_RESET: begin
          cfg_get_req <= 1'b1;
          state_reg   <= bridge_pkg::ST_CONFIG;
        end
        bridge_pkg::ST_CONFIG: begin
          if (cfg_done) begin
            chan_enabled <= cfg_slave_caps;
            state_reg    <= bridge_pkg::ST_IDLE;
          end
        end
        bridge_pkg::ST_IDLE: begin
          if (flash_req) begin
            state_reg <= bridge_pkg::ST_FLASH;
          end else if (reply_cnt_reg != 4'h0) begin
            state_reg <= bridge_pkg::ST_REPLY;
          end
        end
        bridge_pkg::ST_FLASH: begin
          if (flash_done) begin
            state_reg <= bridge_pkg::ST_IDLE;
          end
        end
        bridge_pkg::ST_REPLY: begin
          if (reply_cnt_reg == 4'h1) begin
            state_reg <= bridge_pkg::ST_IDLE;
          end
        end
        default: state_reg <= bridge_pkg::ST_RESET;
      endcase
    end
  end

  // posted/non-posted legality per channel
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rx_reject <= 1'b0;
    end else begin
      rx_reject <= 1'b0;
      if (rx_valid) begin
        case (rx_chan)
          `CH_VWIRE: rx_reject <= ~rx_posted | ~chan_ok;
          `CH_OOB:   rx_reject <= ~rx_posted | ~chan_ok;
          `CH_FLASH: rx_reject <= rx_posted | ~chan_ok;
          default:   rx_reject <= ~chan_ok;
        endcase
      end
    end
  end

  // peripheral channel: outbound ranges gated, inbound memory to host
  always_ff @(posedge core_clk) begin
    if (srst) begin
      periph_fwd   <= 1'b0;
      host_mem_fwd <= 1'b0;
    end else begin
      periph_fwd   <= chan_enabled[`CH_PERIPH] & range_en &
                      ((host_io_req & (host_in_fixed | host_in_prog)) | (host_mem_req & host_in_prog));
      host_mem_fwd <= rx_valid & (rx_chan == `CH_PERIPH) & chan_ok;
    end
  end

  // outbound wires: deep sleep group on its own power-good domain
  always_ff @(posedge core_clk) begin
    if (srst || !link_rst_s[1]) begin
      vw_out_reg_o <= 4'h0;
    end else begin
      vw_out_reg_o <= {sleep_a_wire, platform_reset_wire, suspend_powerdown_ack_wire, suspend_status_wire};
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || !dsw_ok_s) begin
      vw_deep_reg_o <= 5'h0;
    end else begin
      vw_deep_reg_o <= deep_sleep_wires;
    end
  end

  // inbound wires: rx_addr selects the wire, bit 0 of rx_byte its level
  always_ff @(posedge core_clk) begin
    if (srst || !link_rst_s[1]) begin
      power_event_wire <= 1'b1;
      wake_wire        <= 1'b1;
    end else if (rx_valid && rx_chan == `CH_VWIRE && chan_ok && rx_posted) begin
      if (rx_addr == 8'h80) power_event_wire <= rx_byte[0];
      if (rx_addr == 8'h81) wake_wire <= rx_byte[0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || !link_rst_s[0]) begin
      system_mgmt_irq_wire    <= 1'b1;
      system_control_irq_wire <= 1'b1;
      keyboard_reset_wire     <= 1'b1;
    end else if (rx_valid && rx_chan == `CH_VWIRE && chan_ok && rx_posted) begin
      if (rx_addr == 8'h82) system_mgmt_irq_wire <= rx_byte[0];
      if (rx_addr == 8'h83) system_control_irq_wire <= rx_byte[0];
      if (rx_addr == 8'h84) keyboard_reset_wire <= rx_byte[0];
    end
  end

  // irq groups (addr below 0x80) pass straight through; no per-line state
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_msg_valid <= 1'b0;
      irq_msg_line  <= 8'h0;
      irq_msg_level <= 1'b0;
    end else begin
      irq_msg_valid <= rx_valid & (rx_chan == `CH_VWIRE) & chan_ok & rx_posted & ~rx_addr[7];
      irq_msg_line  <= {1'b0, rx_byte[6:0]};
      irq_msg_level <= rx_byte[7];
    end
  end

  // management packets are bytes forwarded unchanged
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mgmt_valid <= 1'b0;
      mgmt_byte  <= 8'h0;
      mgmt_last  <= 1'b0;
    end else begin
      mgmt_valid <= rx_valid & (rx_chan == `CH_OOB) & chan_ok & rx_posted &
                    (rx_addr != `OOB_TEMP_ADDR) & (rx_addr != `OOB_TIME_ADDR);
      mgmt_byte  <= rx_byte;
      mgmt_last  <= rx_last;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      temp_reg <= 8'h0;
    end else if (temp_tick) begin
      temp_reg <= thermal_byte;
    end
  end

  // whole capture in one cycle so the reply never mixes intervals
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rtc_snap_reg <= 56'h0;
      rtc_flag_reg <= 3'h0;
    end else if (rtc_tick) begin
      rtc_snap_reg <= rtc_bytes;
      rtc_flag_reg <= {rtc_binary, rtc_24h, rtc_dst};
    end
  end

  // reply shifter: low byte goes out first
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reply_reg     <= 72'h0;
      reply_cnt_reg <= 4'h0;
    end else if (state_reg == bridge_pkg::ST_REPLY) begin
      reply_reg     <= {8'h0, reply_reg[71:8]};
      reply_cnt_reg <= reply_cnt_reg - 4'h1;
    end else if (reply_cnt_reg == 4'h0 && rx_valid && rx_last && rx_chan == `CH_OOB && chan_ok) begin
      if (rx_addr == `OOB_TEMP_ADDR) begin
        reply_reg     <= {64'h0, temp_reg};
        reply_cnt_reg <= 4'h1;
      end else if (rx_addr == `OOB_TIME_ADDR) begin
        reply_reg     <= {rtc_snap_reg, 5'h0, rtc_flag_reg, 8'h0};
        reply_cnt_reg <= 4'(`TIME_BYTES + 2);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      oob_tx_valid <= 1'b0;
      oob_tx_byte  <= 8'h0;
      oob_tx_last  <= 1'b0;
    end else begin
      oob_tx_valid <= state_reg == bridge_pkg::ST_REPLY;
      oob_tx_byte  <= reply_reg[7:0];
      oob_tx_last  <= (state_reg == bridge_pkg::ST_REPLY) && reply_cnt_reg == 4'h1;
    end
  end

  // flash: legal cycles go to the controller, others completed locally
  always_ff @(posedge core_clk) begin
    if (srst) begin
      flash_req        <= 1'b0;
      flash_cycle      <= `FL_READ;
      flash_data       <= 8'h0;
      flash_cpl_valid  <= 1'b0;
      flash_cpl_status <= `CPL_OK;
      flash_cpl_data   <= 8'h0;
    end else begin
      flash_req       <= 1'b0;
      flash_cpl_valid <= 1'b0;
      if (state_reg == bridge_pkg::ST_FLASH && flash_done) begin
        flash_cpl_valid  <= 1'b1;
        flash_cpl_status <= `CPL_OK;
        flash_cpl_data   <= flash_rdata;
      end else if (state_reg == bridge_pkg::ST_IDLE && !flash_req && rx_valid && rx_last &&
                   rx_chan == `CH_FLASH && chan_ok && !rx_posted) begin
        if (rx_cycle == `FL_READ || rx_cycle == `FL_WRITE || rx_cycle == `FL_ERASE) begin
          flash_req   <= 1'b1;
          flash_cycle <= rx_cycle;
          flash_data  <= rx_byte;
        end else begin
          flash_cpl_valid  <= 1'b1;
          flash_cpl_status <= `CPL_UNSUCC;
          flash_cpl_data   <= 8'h0;
        end
      end
    end
  end

  property p_cfg_after_reset;
    @(posedge core_clk) disable iff (srst)
      (state_reg == bridge_pkg::ST_RESET && link_rst_s[1]) |=> cfg_get_req;
  endproperty
  a_cfg_after_reset: assert property (p_cfg_after_reset) else $error("no config request");

  property p_vw_posted;
    @(posedge core_clk) disable iff (srst)
      (rx_valid && rx_chan == `CH_VWIRE && !rx_posted) |=> rx_reject;
  endproperty
  a_vw_posted: assert property (p_vw_posted) else $error("nonposted vw accepted");

  property p_oob_posted;
    @(posedge core_clk) disable iff (srst)
      (rx_valid && rx_chan == `CH_OOB && !rx_posted) |=> rx_reject;
  endproperty
  a_oob_posted: assert property (p_oob_posted) else $error("nonposted oob accepted");

  property p_flash_np;
    @(posedge core_clk) disable iff (srst)
      (rx_valid && rx_chan == `CH_FLASH && rx_posted) |=> rx_reject;
  endproperty
  a_flash_np: assert property (p_flash_np) else $error("posted flash accepted");

  property p_bad_cycle;
    @(posedge core_clk) disable iff (srst)
      flash_req |-> flash_cycle != 2'h3;
  endproperty
  a_bad_cycle: assert property (p_bad_cycle) else $error("bad flash cycle forwarded");

  sequence s_time_start;
    oob_tx_valid && !$past(oob_tx_valid) && $past(reply_cnt_reg, 2) == 4'(`TIME_BYTES + 2);
  endsequence
  property p_time_len;
    @(posedge core_clk) disable iff (srst)
      s_time_start |-> oob_tx_valid [*8] ##1 (oob_tx_valid && oob_tx_last);
  endproperty
  a_time_len: assert property (p_time_len) else $error("time packet length wrong");

  property p_temp_snap;
    @(posedge core_clk) disable iff (srst)
      temp_tick |=> temp_reg == $past(thermal_byte);
  endproperty
  a_temp_snap: assert property (p_temp_snap) else $error("temperature not refreshed");

  property p_irq_passthru;
    @(posedge core_clk) disable iff (srst)
      (rx_valid && rx_chan == `CH_VWIRE && chan_ok && rx_posted && !rx_addr[7])
        |=> irq_msg_valid && irq_msg_level == $past(rx_byte[7]);
  endproperty
  a_irq_passthru: assert property (p_irq_passthru) else $error("irq message missing");
endmodule
`default_nettype wire

// ---- slave_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module slave_model #(
  parameter logic [3:0] CAPS = 4'hf
) (
  input  wire logic       core_clk,
  input  wire logic       cfg_get_req,
  output var  logic       link_clk,
  output var  logic       cfg_done,
  output var  logic [3:0] cfg_slave_caps,
  output var  logic       rx_valid,
  output var  logic [1:0] rx_chan,
  output var  logic       rx_posted,
  output var  logic [7:0] rx_byte,
  output var  logic [7:0] rx_addr,
  output var  logic [1:0] rx_cycle,
  output var  logic       rx_last
);
  logic framing;
  initial begin
    {link_clk, framing, cfg_done, cfg_slave_caps, rx_valid, rx_chan, rx_posted} = '0;
    {rx_byte, rx_addr, rx_cycle, rx_last} = '0;
  end
  // link clock stands still low outside frames
  always #200 link_clk = framing ? ~link_clk : 1'b0;
  // answer configuration slowly, like a real slave
  always @(posedge core_clk) begin
    if (cfg_get_req === 1'b1) begin
      repeat (5) @(negedge core_clk);
      cfg_slave_caps = CAPS;
      cfg_done = 1'b1;
    end
  end
  task automatic send(input logic [1:0] ch, input logic pst, input logic [7:0] ad,
                      input logic [1:0] cy, input logic [7:0] b[$]);
    framing = 1'b1;
    foreach (b[i]) begin
      @(negedge core_clk);
      {rx_valid, rx_chan, rx_posted, rx_addr, rx_cycle} = {1'b1, ch, pst, ad, cy};
      rx_byte = b[i];
      rx_last = (i == b.size() - 1);
    end
    @(negedge core_clk);
    rx_valid = 1'b0;
    rx_last = 1'b0;
    // a released bus must not look like it still holds the last byte
    rx_byte = ~rx_byte;
    rx_addr = ~rx_addr;
    framing = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb_espi_channel_bridge.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "bridge_params.svh"
module tb_espi_channel_bridge;
  logic        core_clk, srst, link_reset_n, platform_reset_n, deep_sleep_power_good;
  logic        link_clk, cfg_done, cfg_get_req;
  logic [3:0]  cfg_slave_caps, chan_enabled, vw_out_reg_o;
  logic        rx_valid, rx_posted, rx_last, rx_reject;
  logic [1:0]  rx_chan, rx_cycle, flash_cycle, flash_cpl_status;
  logic [7:0]  rx_byte, rx_addr, irq_msg_line, mgmt_byte, thermal_byte, oob_tx_byte;
  logic [7:0]  flash_data, flash_rdata, flash_cpl_data, fdat;
  logic        host_io_req, host_mem_req, host_in_fixed, host_in_prog, range_en, periph_fwd, host_mem_fwd;
  logic        suspend_status_wire, suspend_powerdown_ack_wire, platform_reset_wire, sleep_a_wire;
  logic [4:0]  deep_sleep_wires, vw_deep_reg_o;
  logic        power_event_wire, wake_wire, system_mgmt_irq_wire, system_control_irq_wire;
  logic        keyboard_reset_wire, irq_msg_valid, irq_msg_level, mgmt_valid, mgmt_last;
  logic        oob_tx_valid, oob_tx_last, rtc_dst, rtc_24h, rtc_binary;
  logic        flash_req, flash_done, flash_cpl_valid;
  logic [55:0] rtc_bytes;
  logic [1:0]  fcyc;
  logic [8:0]  mq[$], tq[$], iq[$];
  logic [9:0]  cq[$];
  int          errors, n_checks, nfwd, nreq, cyc, nrej;

  espi_channel_bridge uut (.*);
  slave_model slave (.*);

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc <= srst ? 0 : cyc + 1;
    if (mgmt_valid === 1'b1) mq.push_back({mgmt_last, mgmt_byte});
    if (oob_tx_valid === 1'b1) tq.push_back({oob_tx_last, oob_tx_byte});
    if (irq_msg_valid === 1'b1) iq.push_back({irq_msg_level, irq_msg_line});
    if (flash_cpl_valid === 1'b1) cq.push_back({flash_cpl_status, flash_cpl_data});
    if (host_mem_fwd === 1'b1) nfwd++;
    if (rx_reject === 1'b1) nrej++;
  end

  // flash controller stand-in, answers a few cycles late
  always @(posedge core_clk) begin
    if (flash_req === 1'b1) begin
      nreq++;
      fcyc = flash_cycle;
      fdat = flash_data;
      repeat (3) @(negedge core_clk);
      flash_rdata = 8'h5a ^ fdat;
      flash_done = 1'b1;
      @(negedge core_clk);
      flash_done = 1'b0;
    end
  end

  task automatic finish_test();
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [15:0] probe(input int k);
    case (k)
      0: return 16'(mq.size());
      1: return 16'(tq.size());
      2: return 16'(iq.size());
      3: return 16'(cq.size());
      4: return {12'h0, vw_out_reg_o};
      5: return {11'h0, vw_deep_reg_o};
      6: return {12'h0, chan_enabled};
      default: return {11'h0, power_event_wire, wake_wire, system_mgmt_irq_wire,
                       system_control_irq_wire, keyboard_reset_wire};
    endcase
  endfunction

  // bounded wait for a value, then judge it
  task automatic wait_for(input string nm, input int k, input logic [15:0] v);
    for (int i = 0; i < 80 && probe(k) !== v; i++) @(negedge core_clk);
    check(nm, v, probe(k));
    if (probe(k) !== v) finish_test();
  endtask

  task automatic t_periph();
    logic [5:0] tbl[6] = '{6'b101011, 6'b100111, 6'b100100, 6'b010111, 6'b011010, 6'b001110};
    foreach (tbl[i]) begin
      @(negedge core_clk);
      {host_io_req, host_mem_req, host_in_fixed, host_in_prog, range_en} = tbl[i][5:1];
      @(negedge core_clk);
      check("periph_fwd", 16'(tbl[i][0]), 16'(periph_fwd));
    end
    {host_io_req, host_mem_req} = 2'b00;
    nfwd = 0;
    slave.send(`CH_PERIPH, 1'b0, 8'h00, 2'h0, {8'h11, 8'h22});
    repeat (2) @(negedge core_clk);
    check("host_mem_fwd", 16'h2, 16'(nfwd));
  endtask

  task automatic t_vwire();
    {sleep_a_wire, platform_reset_wire, suspend_powerdown_ack_wire, suspend_status_wire} = 4'ha;
    wait_for("vw_out", 4, 16'ha);
    {sleep_a_wire, platform_reset_wire, suspend_powerdown_ack_wire, suspend_status_wire} = 4'h5;
    wait_for("vw_out", 4, 16'h5);
    deep_sleep_wires = 5'h15;
    wait_for("vw_deep", 5, 16'h15);
    deep_sleep_power_good = 1'b0;
    wait_for("vw_deep", 5, 16'h0);
    deep_sleep_power_good = 1'b1;
    for (int i = 0; i < 5; i++) slave.send(`CH_VWIRE, 1'b1, 8'h80 + 8'(i), 2'h0, {8'h00});
    wait_for("vw_in", 7, 16'h0);
    platform_reset_n = 1'b0;
    repeat (4) @(negedge core_clk);
    platform_reset_n = 1'b1;
    // only the wires in the platform reset domain return high
    wait_for("vw_in", 7, 16'h07);
    iq.delete();
    // several irq groups in one packet, the same level twice
    slave.send(`CH_VWIRE, 1'b1, 8'h10, 2'h0, {8'h85, 8'h85, 8'h05});
    wait_for("irq_cnt", 2, 16'h3);
    check("irq0", 16'h105, 16'(iq[0]));
    check("irq1", 16'h105, 16'(iq[1]));
    check("irq2", 16'h005, 16'(iq[2]));
  endtask

  task automatic t_oob();
    mq.delete();
    slave.send(`CH_OOB, 1'b1, 8'h10, 2'h0, {8'h0f, 8'h20, 8'hf1});
    wait_for("mgmt_cnt", 0, 16'h3);
    check("mgmt0", 16'h00f, 16'(mq[0]));
    check("mgmt1", 16'h020, 16'(mq[1]));
    check("mgmt2", 16'h1f1, 16'(mq[2]));
    // illegal posting per channel: each byte rejected, nothing forwarded
    slave.send(`CH_VWIRE, 1'b0, 8'h10, 2'h0, {8'h85});
    slave.send(`CH_OOB, 1'b0, 8'h10, 2'h0, {8'h0f});
    slave.send(`CH_FLASH, 1'b1, 8'h00, 2'h0, {8'h30});
    repeat (2) @(negedge core_clk);
    check("rx_reject", 16'h3, 16'(nrej));
    check("irq_cnt", 16'h3, 16'(iq.size()));
    check("mgmt_cnt", 16'h3, 16'(mq.size()));
    check("flash_reqs", 16'h0, 16'(nreq));
  endtask

  task automatic t_flash();
    int n0;
    for (int c = 0; c < 4; c++) begin
      cq.delete();
      n0 = nreq;
      slave.send(`CH_FLASH, 1'b0, 8'h00, 2'(c), {8'h30 + 8'(c)});
      wait_for("cpl_cnt", 3, 16'h1);
      if (c < 3) begin
        check("flash_cycle", 16'(c), 16'(fcyc));
        check("flash_data", 16'h30 + 16'(c), 16'(fdat));
        check("cpl", {6'h0, `CPL_OK, 8'h5a ^ (8'h30 + 8'(c))}, 16'(cq[0]));
      end else begin
        check("cpl_status", 16'(`CPL_UNSUCC), 16'(cq[0][9:8]));
        check("flash_reqs", 16'(n0), 16'(nreq));
      end
      repeat (3) @(negedge core_clk);
    end
  endtask

  task automatic t_reply(input logic [7:0] et, input logic [55:0] er, input logic [7:0] ef);
    tq.delete();
    slave.send(`CH_OOB, 1'b1, `OOB_TEMP_ADDR, 2'h0, {8'h00});
    wait_for("temp_cnt", 1, 16'h1);
    check("temp", {8'h1, et}, 16'(tq[0]));
    tq.delete();
    slave.send(`CH_OOB, 1'b1, `OOB_TIME_ADDR, 2'h0, {8'h00});
    wait_for("time_cnt", 1, 16'(2 + `TIME_BYTES));
    check("time_hdr", 16'h0, 16'(tq[0]));
    check("time_flags", 16'(ef), 16'(tq[1]));
    for (int i = 0; i < 7; i++) check("time", {7'h0, i == 6, er[8*i+:8]}, 16'(tq[i+2]));
  endtask

  task automatic t_snap();
    for (int i = 0; i < 21000 && cyc < 20100; i++) @(negedge core_clk);
    // new inputs must not show before the next capture
    thermal_byte = 8'h41;
    rtc_bytes = 56'h180c1f03173b3a;
    {rtc_dst, rtc_24h, rtc_binary} = 3'b011;
    t_reply(8'h3c, 56'h2412310491595a, 8'h01);
    for (int i = 0; i < 21000 && cyc < 40100; i++) @(negedge core_clk);
    t_reply(8'h41, 56'h180c1f03173b3a, 8'h06);
  endtask

  initial begin
    {srst, link_reset_n, platform_reset_n, deep_sleep_power_good} = 4'hf;
    {host_io_req, host_mem_req, host_in_fixed, host_in_prog, range_en} = 5'h0;
    {suspend_status_wire, suspend_powerdown_ack_wire, platform_reset_wire, sleep_a_wire} = 4'h0;
    {deep_sleep_wires, flash_done, flash_rdata} = '0;
    thermal_byte = 8'h3c;
    rtc_bytes = 56'h2412310491595a;
    {rtc_dst, rtc_24h, rtc_binary} = 3'b100;
    repeat (6) @(negedge core_clk);
    srst = 1'b0;
    @(negedge core_clk);
    check("wires_in", 16'h1f, probe(7));
    wait_for("chan_enabled", 6, 16'hf);
    t_periph();
    t_vwire();
    t_oob();
    t_flash();
    t_snap();
    finish_test();
  end
endmodule
`default_nettype wire
